// ### hw/piu_pkg.sv
// Constants, types and register map of the prioritised interrupt unit
package piu_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int NUM_SRC    = 13;
  localparam int NUM_EXT    = 2;
  localparam int SRC_ID_W   = 4;
  localparam int AXI_ADDR_W = 8;
  localparam int SP_W       = 8;

  // ****************************************************************
  // Register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam logic [7:0] OFF_ENABLE_HIGH  = 8'h00;
  localparam logic [7:0] OFF_ENABLE_LOW   = 8'h04;
  localparam logic [7:0] OFF_REQUEST_HIGH = 8'h08;
  localparam logic [7:0] OFF_REQUEST_LOW  = 8'h0C;
  localparam logic [7:0] OFF_EDGE_SELECT  = 8'h10;
  localparam logic [7:0] OFF_STATUS_WORD  = 8'h14;
  localparam logic [7:0] OFF_STACK_PTR    = 8'h18;
  localparam logic [7:0] OFF_UNIT_STATE   = 8'h1C;

  // ****************************************************************
  // Fields and reset values
  // ****************************************************************
  localparam int         PSW_IE_BIT     = 2;
  localparam logic [7:0] PSW_RESET      = 8'h00;
  localparam logic [7:0] SP_RESET       = 8'hFF;
  localparam logic [3:0] EDGE_RESET     = 4'h0;
  localparam logic [1:0] EDGE_FALL_BIT  = 2'h1;
  localparam logic [1:0] EDGE_RISE_BIT  = 2'h2;
  localparam int         ACCEPT_CYCLES  = 8;
  localparam logic [1:0] RESP_OKAY      = 2'h0;
  localparam logic [1:0] RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic instrDone;
    logic retiExec;
    logic eiExec;
    logic brkExec;
  } piu_core_cmd_s;

  typedef enum logic [13:0] {
    ST_IDLE    = 14'h0001,
    ST_ACC     = 14'h0002,
    ST_PUSH_H  = 14'h0004,
    ST_PUSH_L  = 14'h0008,
    ST_PUSH_P  = 14'h0010,
    ST_VEC_LO  = 14'h0020,
    ST_VEC_HI  = 14'h0040,
    ST_VEC_CAP = 14'h0080,
    ST_LOAD    = 14'h0100,
    ST_RET_A   = 14'h0200,
    ST_RET_B   = 14'h0400,
    ST_RET_C   = 14'h0800,
    ST_RET_D   = 14'h1000,
    ST_RET_E   = 14'h2000
  } piu_state_e;

endpackage

// ### hw/piu_stack_ram.sv
// Byte-wide stack memory with registered read data
`timescale 1ns/10ps
module piu_stack_ram #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          clock,
  input  wire logic          wrEn,
  input  wire logic [AW-1:0] wrAddr,
  input  wire logic [DW-1:0] wrData,
  input  wire logic [AW-1:0] rdAddr,
  output logic      [DW-1:0] rdData
);

  logic [DW-1:0] memArray [0:(1<<AW)-1];

  always_ff @(posedge clock)
  begin
    if (wrEn)
    begin
      memArray[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clock)
  begin
    rdData <= memArray[rdAddr];
  end

endmodule

// ### hw/piu_prioritized_interrupt_unit.sv
// Prioritised interrupt unit: request latching, priority and acceptance
//
// Overview of operation
// - Thirteen maskable sources, each with own request flag and enable flag.
// - Each external pin raises its request on the selected transition.
// - External request flag is cleared by hardware when vectored.
// - Each timer match sets that timer's request flag.
// - Interval timer overflow sets its request flag.
// - Conversion done and watchdog match each set their request flag.
// - Maskable request taken only if flag, enable and master enable set.
// - Pending enabled requests served in fixed order, source 0 first.
// - A source whose enable flag is zero is never accepted.
// - Latched request pends until accepted, reset or cleared by software.
// - Acceptance starts after instruction completion and lasts 8 cycles.
// - Maskable accept clears master enable; break acceptance blocks all requests.
// - The accepted source's request flag is cleared during acceptance.
// - Return address and status word pushed, stack pointer down three.
// - Entry address fetched from vector table and loaded into PC.
// - Service ends when the return-from-interrupt instruction executes.
// - With master enable clear, no maskable request is accepted at all.
// - Per pin edge modes: rising, falling or both, by edge selection.
// - Simultaneous requests resolved by fixed hardware polling order.
`timescale 1ns/10ps
module piu_prioritized_interrupt_unit
  import piu_pkg::*;
#(
  parameter logic [15:0] VEC_TABLE_BASE = 16'hFFE0,
  parameter logic [15:0] BRK_VECTOR     = 16'hFFDE
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic [piu_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                       s_axi_awvalid,
  output logic                            s_axi_awready,
  input  wire logic [31:0]                s_axi_wdata,
  input  wire logic [3:0]                 s_axi_wstrb,
  input  wire logic                       s_axi_wvalid,
  output logic                            s_axi_wready,
  output logic [1:0]                      s_axi_bresp,
  output logic                            s_axi_bvalid,
  input  wire logic                       s_axi_bready,
  input  wire logic [piu_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                       s_axi_arvalid,
  output logic                            s_axi_arready,
  output logic [31:0]                     s_axi_rdata,
  output logic [1:0]                      s_axi_rresp,
  output logic                            s_axi_rvalid,
  input  wire logic                       s_axi_rready,
  input  wire logic                       extIrqPinA,
  input  wire logic                       extIrqPinB,
  input  wire logic                       remoteRiseSource,
  input  wire logic                       remoteFallSource,
  input  wire logic                       remoteOverflowSource,
  input  wire logic                       keyscanSource,
  input  wire logic                       serialPortA,
  input  wire logic                       serialPortB,
  input  wire logic                       timer0Match,
  input  wire logic                       timer1Match,
  input  wire logic                       conversionDone,
  input  wire logic                       watchdogMatch,
  input  wire logic                       intervalOverflow,
  input  wire piu_pkg::piu_core_cmd_s     coreCmd,
  input  wire logic [15:0]                returnAddr,
  input  wire logic [7:0]                 vecData,
  output logic                            busy,
  output logic                            pcLoad,
  output logic [15:0]                     pcValue,
  output logic [15:0]                     vecAddr,
  output logic                            vecRd,
  output logic [7:0]                      processorStatusWord
);

  import piu_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  piu_state_e            stateReg;
  logic [NUM_SRC-1:0]    enableReg;
  logic [NUM_SRC-1:0]    requestReg;
  logic [NUM_SRC-1:0]    srcEvent;
  logic [NUM_SRC-1:0]    pending;
  logic [NUM_EXT-1:0]    extPins;
  logic [NUM_EXT-1:0]    pinPrevReg;
  logic [NUM_EXT-1:0]    extEvent;
  logic [3:0]            edgeSelReg;
  logic [7:0]            pswReg;
  logic [7:0]            pswSaveReg;
  logic [SP_W-1:0]       spReg;
  logic [15:0]           retAddrReg;
  logic [7:0]            byteLoReg;
  logic [SRC_ID_W-1:0]   srcIdReg;
  logic [SRC_ID_W-1:0]   pickId;
  logic                  isBrkReg;
  logic                  brkPendReg;
  logic                  nmiBlockReg;
  logic                  maskOk;
  logic                  takeAccept;
  logic [7:0]            awaddrReg;
  logic [7:0]            wdataReg;
  logic                  wstrbReg;
  logic                  wrFire;
  logic                  wrEn;
  logic                  addrMapped;
  logic [31:0]           readWord;
  logic                  stWe;
  logic [7:0]            stWrData;
  logic [SP_W-1:0]       stRdAddr;
  logic [7:0]            stRdData;

  function automatic logic [7:0] highByte(input logic [NUM_SRC-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      b[7-i] = v[i];
    end
    return b;
  endfunction

  function automatic logic [7:0] lowByte(input logic [NUM_SRC-1:0] v);
    logic [7:0] b;
    b = 8'h00;
    for (int i = 8; i < NUM_SRC; i++)
    begin
      b[15-i] = v[i];
    end
    return b;
  endfunction

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  assign wrEn   = wrFire && wstrbReg;

  always_comb
  begin
    case (awaddrReg)
      OFF_ENABLE_HIGH, OFF_ENABLE_LOW, OFF_REQUEST_HIGH, OFF_REQUEST_LOW,
      OFF_EDGE_SELECT, OFF_STATUS_WORD, OFF_STACK_PTR, OFF_UNIT_STATE:
        addrMapped = 1'b1;
      default:
        addrMapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      awaddrReg     <= 8'h00;
      wdataReg      <= 8'h00;
      wstrbReg      <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddrReg     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdataReg     <= s_axi_wdata[7:0];
        wstrbReg     <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addrMapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  always_comb
  begin
    readWord = 32'h0000_0000;
    case (s_axi_araddr)
      OFF_ENABLE_HIGH:  readWord[7:0] = highByte(enableReg);
      OFF_ENABLE_LOW:   readWord[7:0] = lowByte(enableReg);
      OFF_REQUEST_HIGH: readWord[7:0] = highByte(requestReg);
      OFF_REQUEST_LOW:  readWord[7:0] = lowByte(requestReg);
      OFF_EDGE_SELECT:  readWord[3:0] = edgeSelReg;
      OFF_STATUS_WORD:  readWord[7:0] = pswReg;
      OFF_STACK_PTR:    readWord[7:0] = spReg;
      OFF_UNIT_STATE:   readWord[7:0] = {busy, nmiBlockReg, brkPendReg,
                                         isBrkReg, srcIdReg};
      default:          readWord = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= readWord;
        s_axi_rresp   <= (s_axi_araddr > OFF_UNIT_STATE ||
                          s_axi_araddr[1:0] != 2'h0) ? RESP_SLVERR
                                                     : RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Request sources, flags and enables
  // ****************************************************************
  assign extPins  = {extIrqPinB, extIrqPinA};
  assign srcEvent = {intervalOverflow,
                     watchdogMatch, conversionDone,
                     timer1Match, timer0Match,
                     serialPortB, serialPortA, keyscanSource,
                     remoteOverflowSource, remoteFallSource,
                     remoteRiseSource, extEvent};

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pinPrevReg <= '0;
      edgeSelReg <= EDGE_RESET;
    end
    else
    begin
      pinPrevReg <= extPins;
      if (wrEn && awaddrReg == OFF_EDGE_SELECT)
      begin
        edgeSelReg <= wdataReg[3:0];
      end
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++)
    begin : g_src
      localparam int         BP  = (gi < 8) ? (7 - gi) : (15 - gi);
      localparam logic [7:0] OFE = (gi < 8) ? OFF_ENABLE_HIGH
                                            : OFF_ENABLE_LOW;
      localparam logic [7:0] OFR = (gi < 8) ? OFF_REQUEST_HIGH
                                            : OFF_REQUEST_LOW;
      logic accClr;

      if (gi < NUM_EXT)
      begin : g_ext
        logic rise;
        logic fall;
        assign rise = extPins[gi] && !pinPrevReg[gi];
        assign fall = !extPins[gi] && pinPrevReg[gi];
        // Mode 01 falling, 10 rising, 11 both, 00 off
        assign extEvent[gi] =
          (edgeSelReg[2*gi+1] && rise) ||
          (edgeSelReg[2*gi]   && fall);
      end

      // Also clears an external flag when vectored
      assign accClr = (stateReg == ST_ACC) && !isBrkReg &&
                      (srcIdReg == SRC_ID_W'(gi));

      // An event in the clearing cycle wins, so it is never lost
      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          requestReg[gi] <= 1'b0;
        end
        else if (srcEvent[gi])
        begin
          requestReg[gi] <= 1'b1;
        end
        else if (accClr)
        begin
          requestReg[gi] <= 1'b0;
        end
        else if (wrEn && awaddrReg == OFR)
        begin
          requestReg[gi] <= wdataReg[BP];
        end
      end

      always_ff @(posedge clock)
      begin
        if (!rst_n)
        begin
          enableReg[gi] <= 1'b0;
        end
        else if (wrEn && awaddrReg == OFE)
        begin
          enableReg[gi] <= wdataReg[BP];
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Priority selection
  // ****************************************************************
  assign pending = requestReg & enableReg;
  assign maskOk  = pswReg[PSW_IE_BIT] && !nmiBlockReg &&
                   (|pending);
  assign takeAccept = coreCmd.instrDone && !nmiBlockReg &&
                      (maskOk || brkPendReg);

  // Lowest index wins; simultaneous arrivals settle on this order too
  always_comb
  begin
    pickId = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        pickId = SRC_ID_W'(i);
      end
    end
  end

  // ****************************************************************
  // Status word and break handling
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      pswReg <= PSW_RESET;
    end
    else if (stateReg == ST_RET_B)
    begin
      pswReg <= stRdData;
    end
    else if (stateReg == ST_ACC && !isBrkReg)
    begin
      pswReg[PSW_IE_BIT] <= 1'b0;
    end
    else if (coreCmd.eiExec)
    begin
      pswReg[PSW_IE_BIT] <= 1'b1;
    end
    else if (wrEn && awaddrReg == OFF_STATUS_WORD)
    begin
      pswReg <= wdataReg;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      brkPendReg  <= 1'b0;
      nmiBlockReg <= 1'b0;
    end
    else
    begin
      if (coreCmd.brkExec)
      begin
        brkPendReg <= 1'b1;
      end
      else if (stateReg == ST_ACC && isBrkReg)
      begin
        brkPendReg <= 1'b0;
      end
      if (stateReg == ST_ACC && isBrkReg)
      begin
        nmiBlockReg <= 1'b1;
      end
      else if (stateReg == ST_RET_E)
      begin
        nmiBlockReg <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Stack pointer and stack memory
  // ****************************************************************
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      spReg <= SP_RESET;
    end
    else
    begin
      case (stateReg)
        ST_PUSH_H, ST_PUSH_L, ST_PUSH_P:
          spReg <= spReg - SP_W'(1);
        ST_RET_A, ST_RET_B, ST_RET_C:
          spReg <= spReg + SP_W'(1);
        default:
        begin
          if (wrEn && awaddrReg == OFF_STACK_PTR)
          begin
            spReg <= wdataReg;
          end
        end
      endcase
    end
  end

  assign stWe     = (stateReg == ST_PUSH_H) || (stateReg == ST_PUSH_L) ||
                    (stateReg == ST_PUSH_P);
  assign stRdAddr = spReg + SP_W'(1);

  always_comb
  begin
    case (stateReg)
      ST_PUSH_H: stWrData = retAddrReg[15:8];
      ST_PUSH_L: stWrData = retAddrReg[7:0];
      default:   stWrData = pswSaveReg;
    endcase
  end

  piu_stack_ram #(
    .AW (SP_W),
    .DW (8)
  ) u_stack (
    .clock  (clock),
    .wrEn   (stWe),
    .wrAddr (spReg),
    .wrData (stWrData),
    .rdAddr (stRdAddr),
    .rdData (stRdData)
  );

  // ****************************************************************
  // Acceptance and return sequencer
  // ****************************************************************
  // The core is stalled on busy, so eight busy cycles per acceptance
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      stateReg   <= ST_IDLE;
      busy       <= 1'b0;
      pcLoad     <= 1'b0;
      pcValue    <= 16'h0000;
      vecAddr    <= 16'h0000;
      vecRd      <= 1'b0;
      srcIdReg   <= '0;
      isBrkReg   <= 1'b0;
      retAddrReg <= 16'h0000;
      pswSaveReg <= 8'h00;
      byteLoReg  <= 8'h00;
    end
    else
    begin
      pcLoad <= 1'b0;
      case (stateReg)
        ST_IDLE:
        begin
          if (coreCmd.retiExec)
          begin
            stateReg <= ST_RET_A;
            busy     <= 1'b1;
          end
          else if (takeAccept)
          begin
            stateReg   <= ST_ACC;
            busy       <= 1'b1;
            srcIdReg   <= pickId;
            isBrkReg   <= !maskOk;
            retAddrReg <= returnAddr;
          end
        end
        ST_ACC:
        begin
          pswSaveReg <= pswReg;
          stateReg   <= ST_PUSH_H;
        end
        ST_PUSH_H: stateReg <= ST_PUSH_L;
        ST_PUSH_L: stateReg <= ST_PUSH_P;
        ST_PUSH_P:
        begin
          vecAddr  <= isBrkReg ? BRK_VECTOR
                    : VEC_TABLE_BASE + 16'({srcIdReg, 1'b0});
          vecRd    <= 1'b1;
          stateReg <= ST_VEC_LO;
        end
        ST_VEC_LO:
        begin
          vecAddr  <= vecAddr + 16'h0001;
          stateReg <= ST_VEC_HI;
        end
        ST_VEC_HI:
        begin
          byteLoReg <= vecData;
          vecRd     <= 1'b0;
          stateReg  <= ST_VEC_CAP;
        end
        ST_VEC_CAP:
        begin
          pcValue  <= {vecData, byteLoReg};
          pcLoad   <= 1'b1;
          stateReg <= ST_LOAD;
        end
        ST_LOAD:
        begin
          busy     <= 1'b0;
          stateReg <= ST_IDLE;
        end
        ST_RET_A: stateReg <= ST_RET_B;
        ST_RET_B: stateReg <= ST_RET_C;
        ST_RET_C:
        begin
          byteLoReg <= stRdData;
          stateReg  <= ST_RET_D;
        end
        ST_RET_D:
        begin
          pcValue  <= {stRdData, byteLoReg};
          pcLoad   <= 1'b1;
          stateReg <= ST_RET_E;
        end
        ST_RET_E:
        begin
          busy     <= 1'b0;
          stateReg <= ST_IDLE;
        end
        default:
        begin
          busy     <= 1'b0;
          vecRd    <= 1'b0;
          stateReg <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      processorStatusWord <= PSW_RESET;
    end
    else
    begin
      processorStatusWord <= pswReg;
    end
  end

endmodule

// ### sim/piu_monitor.sv
// Checker on the core side of the interrupt unit
`timescale 1ns/10ps
module piu_monitor
  import piu_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic        busy,
  input wire logic        pcLoad,
  input wire logic [15:0] vecAddr,
  input wire logic        vecRd,
  input wire logic [7:0]  processorStatusWord
);
  // ************
  // Acceptance
  // ************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_fetch;
    vecRd ##1 vecRd ##1 !vecRd ##1 pcLoad;
  endsequence
  a_fetch_order: assert property ($rose(vecRd) |-> s_fetch)
    else $error("bad fetch");
  a_addr_step: assert property ($rose(vecRd) |=>
    vecAddr == $past(vecAddr) + 16'h0001) else $error("bad step");
  a_accept_len: assert property ($rose(vecRd) |->
    $past(busy, 4) && !$past(busy, 5)) else $error("bad length");
  a_ie_cleared: assert property ($rose(vecRd) |->
    !processorStatusWord[PSW_IE_BIT]) else $error("enable kept");
  a_ie_drop: assert property ($fell(processorStatusWord[PSW_IE_BIT])
    && busy |-> ##2 $rose(vecRd)) else $error("fetch late");
  a_load_busy: assert property (pcLoad |-> busy)
    else $error("load while idle");
  a_load_pulse: assert property (pcLoad |=> !pcLoad)
    else $error("load too long");
  a_busy_end: assert property ($fell(busy) |->
    $past(pcLoad) || $past(pcLoad, 2)) else $error("busy end late");
endmodule

bind piu_prioritized_interrupt_unit piu_monitor piu_monitor_i (
  .clock(clock), .rst_n(rst_n), .busy(busy), .pcLoad(pcLoad),
  .vecAddr(vecAddr), .vecRd(vecRd),
  .processorStatusWord(processorStatusWord));

// ### sim/piu_vec_model.sv
// Program memory model answering vector fetches
`timescale 1ns/10ps
module piu_vec_model (
  input  wire logic        clock,
  input  wire logic        vecRd,
  input  wire logic [15:0] vecAddr,
  output logic      [7:0]  vecData
);
  // Byte flips each cycle outside a fetch, so a sample one cycle late never matches
  always_ff @(posedge clock)
  begin
    if (vecRd)
      vecData <= vecAddr[7:0] ^ 8'hA5;
    else
      vecData <= ~vecData;
  end
endmodule

// ### sim/piu_prioritized_interrupt_unit_tb_top.sv
// Self-checking bench of the interrupt unit
`timescale 1ns/10ps
module piu_prioritized_interrupt_unit_tb_top;
  import piu_pkg::*;
  logic          clock, rst_n, awv, wv, bry, arv, rry, vRd, pA, pB;
  logic          awr, wr_, bv, arr, rv, busy, pcLoad;
  logic [7:0]    aa, ra8, vD, processor_status_word;
  logic [31:0]   wd, rdat;
  logic [1:0]    br, rr;
  logic [12:0]   src;
  logic [15:0]   pcValue, vA;
  piu_core_cmd_s cmd;
  int            err_total, n_tests, cyc, k;
  piu_prioritized_interrupt_unit piu_prioritized_interrupt_unit_i (
    .clock(clock), .rst_n(rst_n), .s_axi_awaddr(aa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(br),
    .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ra8),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
    .extIrqPinA(pA), .extIrqPinB(pB), .remoteRiseSource(src[2]),
    .remoteFallSource(src[3]), .remoteOverflowSource(src[4]),
    .keyscanSource(src[5]), .serialPortA(src[6]), .serialPortB(src[7]),
    .timer0Match(src[8]), .timer1Match(src[9]), .conversionDone(src[10]),
    .watchdogMatch(src[11]), .intervalOverflow(src[12]), .coreCmd(cmd),
    .returnAddr(16'h1234), .vecData(vD), .busy(busy), .pcLoad(pcLoad),
    .pcValue(pcValue), .vecAddr(vA), .vecRd(vRd),
    .processorStatusWord(processor_status_word));
  piu_vec_model piu_vec_model_i (.clock(clock), .vecRd(vRd),
    .vecAddr(vA), .vecData(vD));
  // ************
  // Tasks
  // ************
  task automatic chk(input string n, input logic [15:0] s, e);
    n_tests++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, v);
    @(posedge clock);
    aa <= a;
    wd <= {24'h0, v};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    fork
      begin
        do @(posedge clock); while (awr !== 1'b1);
        awv <= 1'b0;
      end
      begin
        do @(posedge clock); while (wr_ !== 1'b1);
        wv <= 1'b0;
      end
    join
    do @(posedge clock); while (bv !== 1'b1);
    bry <= 1'b0;
    chk("bresp", 16'(br),
        16'(a > OFF_UNIT_STATE ? RESP_SLVERR : RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge clock);
    ra8 <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do @(posedge clock); while (arr !== 1'b1);
    arv <= 1'b0;
    do @(posedge clock); while (rv !== 1'b1);
    rry <= 1'b0;
    chk("rdata", rdat[15:0], e);
    chk("rresp", 16'(rr),
        16'(a > OFF_UNIT_STATE ? RESP_SLVERR : RESP_OKAY));
  endtask
  // Event and core pulses last one cycle each
  task automatic ev(input logic [12:0] s, input logic [3:0] c);
    @(posedge clock);
    src <= s;
    cmd <= c;
    @(posedge clock);
    src <= '0;
    cmd <= '0;
  endtask
  task automatic pcw(input logic [15:0] e, input int lat);
    k = 0;
    do
    begin
      @(posedge clock);
      k++;
    end
    while (pcLoad !== 1'b1);
    chk("pc", pcValue, e);
    chk("latency", 16'(k), 16'(lat));
  endtask
  task automatic idle2();
    repeat (2) @(posedge clock);
    chk("busy", {15'h0, busy}, 16'h0000);
  endtask
  function automatic logic [15:0] vp(input int n);
    logic [7:0] a;
    a = 8'hE0 + 8'(2 * n);
    return {(a + 8'h01) ^ 8'hA5, a ^ 8'hA5};
  endfunction
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ************
  // Sequence
  // ************
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Ceiling well above the roughly two hundred cycles of the run
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      end_sim();
    end
  end
  initial
  begin
    {awv, wv, bry, arv, rry, pA, pB, aa, ra8, wd, src, cmd} = '0;
    {err_total, n_tests, cyc} = '0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(OFF_STACK_PTR, 16'h00FF);
    wr(8'h20, 8'hFF);
    rd(8'h20, 16'h0000);
    wr(OFF_ENABLE_HIGH, 8'hFF);
    wr(OFF_ENABLE_LOW, 8'hF8);
    wr(OFF_STATUS_WORD, 8'h04);
    ev(13'h0600, 4'h0);
    rd(OFF_REQUEST_LOW, 16'h0060);
    ev(13'h0000, 4'h8);
    pcw(vp(9), 8);
    rd(OFF_REQUEST_LOW, 16'h0020);
    rd(OFF_STATUS_WORD, 16'h0000);
    rd(OFF_STACK_PTR, 16'h00FC);
    ev(13'h0000, 4'h8);
    idle2();
    ev(13'h0000, 4'h4);
    pcw(16'h1234, 5);
    rd(OFF_STATUS_WORD, 16'h0004);
    rd(OFF_STACK_PTR, 16'h00FF);
    ev(13'h0000, 4'h8);
    pcw(vp(10), 8);
    ev(13'h0000, 4'h4);
    pcw(16'h1234, 5);
    wr(OFF_ENABLE_LOW, 8'h00);
    ev(13'h1000, 4'h0);
    ev(13'h0000, 4'h8);
    idle2();
    rd(OFF_REQUEST_LOW, 16'h0008);
    wr(OFF_EDGE_SELECT, 8'h09);
    pA <= 1'b1;
    pB <= 1'b1;
    repeat (3) @(posedge clock);
    pA <= 1'b0;
    repeat (2) @(posedge clock);
    rd(OFF_REQUEST_HIGH, 16'h00C0);
    ev(13'h0000, 4'h8);
    pcw(vp(0), 8);
    rd(OFF_REQUEST_HIGH, 16'h0040);
    // Service routine re-enables, so the pending source nests
    ev(13'h0000, 4'h2);
    ev(13'h0000, 4'h8);
    pcw(vp(1), 8);
    // Break is taken with master enable clear and then blocks
    ev(13'h0000, 4'h1);
    ev(13'h0000, 4'h8);
    pcw(16'h7A7B, 8);
    rd(OFF_UNIT_STATE, 16'h0050);
    wr(OFF_EDGE_SELECT, 8'h0B);
    pA <= 1'b1;
    repeat (2) @(posedge clock);
    rd(OFF_REQUEST_HIGH, 16'h0080);
    wr(OFF_REQUEST_HIGH, 8'h00);
    rd(OFF_REQUEST_HIGH, 16'h0000);
    end_sim();
  end
endmodule
